// >>> mif_defs.svh
// Constants of the mouse input front end: timing, addresses, field positions.
// Assumes a 20 MHz system clock and a free-running link clock near 6 ns.
`ifndef MIF_DEFS_SVH
`define MIF_DEFS_SVH

// ----------------------------------------
// System clock timing
// ----------------------------------------
`define MIF_CLK_NS 50
`define MIF_DEBOUNCE_MS 15
`define MIF_DEBOUNCE_CYC (`MIF_DEBOUNCE_MS * 1000000 / `MIF_CLK_NS)
`define MIF_POLL_US 1000
`define MIF_POLL_CYC (`MIF_POLL_US * 1000 / `MIF_CLK_NS)

// ----------------------------------------
// Link timing, serial clock half period rounded up
// ----------------------------------------
`define MIF_LINK_NS 6
`define MIF_SCK_HALF_NS 500
`define MIF_SCK_HALF_CYC ((`MIF_SCK_HALF_NS + `MIF_LINK_NS - 1) / `MIF_LINK_NS)

// ----------------------------------------
// Burst framing
// ----------------------------------------
`define MIF_BURST_ADDR 8'h50
`define MIF_ADDR_BITS 8
`define MIF_BURST_BITS 64
`define MIF_MOTION_BIT 7
`define MIF_BUF_DEPTH 2

`endif

// >>> mif_pkg.sv
// Types shared by the mouse input front end, its checker and its bench.
// Needs no other file.
package mif_pkg;

    // ----------------------------------------
    // Burst bytes in arrival order, first byte highest
    // ----------------------------------------
    typedef struct packed {
        logic [7:0] motion;
        logic [7:0] x_lo;
        logic [7:0] y_lo;
        logic [7:0] xy_move_high;
        logic [7:0] surface_quality;
        logic [7:0] exposure_hi;
        logic [7:0] exposure_lo;
        logic [7:0] peak_pixel;
    } mif_burst_t;

    // ----------------------------------------
    // Report handed to the USB side
    // ----------------------------------------
    typedef struct packed {
        logic [2:0] buttons;
        logic [15:0] dx;
        logic [15:0] dy;
        logic [15:0] dz;
        logic [7:0] surface_quality;
    } mif_report_t;

    typedef enum logic [3:0] {
        LK_IDLE = 4'b0001,
        LK_SHIFT = 4'b0010,
        LK_SLAVE = 4'b0100,
        LK_END = 4'b1000
    } mif_link_st_t;

endpackage

// >>> mif_buf.sv
// Small valid/ready buffer with registered storage.
// Assumes a single clock; depth a power of two.
`timescale 1ns/1ps
`default_nettype none

module mif_buf #(
    parameter int W = 8,
    parameter int DEPTH = 2
) (
    // Clock and reset
    input wire logic clk,
    input wire logic rst,
    // Fill side
    input wire logic in_valid,
    output logic in_ready,
    input wire logic [W-1:0] in_data,
    // Drain side
    output logic out_valid,
    input wire logic out_ready,
    output logic [W-1:0] out_data
);
    localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
    localparam int CW = $clog2(DEPTH + 1);

    if (DEPTH < 2 || (DEPTH & (DEPTH - 1)) != 0) begin : g_chk
        $error("mif_buf: DEPTH must be a power of two, at least 2");
    end

    logic [W-1:0] mem_ff [DEPTH];
    logic [AW-1:0] wr_ptr_ff;
    logic [AW-1:0] rd_ptr_ff;
    logic [CW-1:0] cnt_ff;
    logic push;
    logic pop;

    assign in_ready = (cnt_ff != CW'(DEPTH));
    assign out_valid = (cnt_ff != '0);
    assign push = in_valid & in_ready;
    assign pop = out_valid & out_ready;
    assign out_data = mem_ff[rd_ptr_ff];

    always_ff @(posedge clk) begin
        if (push) begin
            mem_ff[wr_ptr_ff] <= in_data;
        end
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            wr_ptr_ff <= '0;
            rd_ptr_ff <= '0;
            cnt_ff <= '0;
        end else begin
            if (push) begin
                wr_ptr_ff <= wr_ptr_ff + AW'(1);
            end
            if (pop) begin
                rd_ptr_ff <= rd_ptr_ff + AW'(1);
            end
            if (push && !pop) begin
                cnt_ff <= cnt_ff + CW'(1);
            end else if (pop && !push) begin
                cnt_ff <= cnt_ff - CW'(1);
            end
        end
    end

endmodule // mif_buf

`default_nettype wire

// >>> mif_front_end.sv
// Mouse input front end: sensor burst reader, scroll decoder, button debouncer.
// Assumes LINK_CLK runs free; pins and the encoder come from outside both clocks.
`timescale 1ns/1ps
`default_nettype none
`include "mif_defs.svh"

// How it works
// - In master mode a burst starts with one read access of the burst motion register; a slave frame has no address byte.
// - Burst bytes arrive and are stored in the fixed motion-first order.
// - All burst bytes are clocked continuously without a new address per byte.
// - The serial port moves whole bytes and works as master or slave.
// - Every one-position encoder state change counts one scroll step; a two-position jump counts none.
// - Direction comes from comparing previous and current encoder states.
// - A low sampled button level means pressed.
// - A high sampled button level means released.
// - Button changes are accepted only after a stable debounce interval.
// - Exactly three buttons: left, wheel middle, right.
module mif_front_end #(
    parameter int DEBOUNCE_CYC = `MIF_DEBOUNCE_CYC,
    parameter int POLL_CYC = `MIF_POLL_CYC,
    parameter int SCK_HALF_CYC = `MIF_SCK_HALF_CYC,
    parameter logic [7:0] BURST_ADDR = `MIF_BURST_ADDR
) (
    // System clock and reset
    input wire logic CLK,
    input wire logic RST,
    // Link clock
    input wire logic LINK_CLK,
    // Serial port mode, high for slave
    input wire logic SLAVE_MODE,
    // Serial port pins
    input wire logic SCK_I,
    output logic SCK_O,
    output logic SCK_OE,
    input wire logic NCS_I,
    output logic NCS_O,
    output logic NCS_OE,
    output logic MOSI_O,
    input wire logic MISO_I,
    // Scroll encoder
    input wire logic ZA,
    input wire logic ZB,
    // Buttons, active low: left, middle, right
    input wire logic [2:0] BTN_N,
    // Report stream
    output mif_pkg::mif_report_t REPORT,
    output logic REPORT_VALID,
    input wire logic REPORT_READY,
    // Debounced state
    output logic [2:0] BUTTONS_PRESSED
);
    localparam int DW = $clog2(DEBOUNCE_CYC + 1);
    localparam int PW = $clog2(POLL_CYC + 1);
    localparam int SW = $clog2(SCK_HALF_CYC + 1);
    localparam logic [DW-1:0] DEB_LAST = DW'(DEBOUNCE_CYC - 1);
    localparam logic [PW-1:0] POLL_LAST = PW'(POLL_CYC - 1);
    localparam logic [SW-1:0] HALF_LAST = SW'(SCK_HALF_CYC - 1);
    localparam logic [6:0] MST_LAST = 7'(`MIF_ADDR_BITS + `MIF_BURST_BITS - 1);
    localparam logic [6:0] SLV_LAST = 7'(`MIF_BURST_BITS - 1);

    // Two-flop data sync needs a half period of at least three link cycles
    if (DEBOUNCE_CYC < 1 || POLL_CYC < 2 || SCK_HALF_CYC < 3) begin : g_chk
        $error("mif_front_end: counts too small");
    end

    function automatic logic [15:0] sat_add(input logic [15:0] a, input logic [15:0] b);
        logic [16:0] s;
        s = {a[15], a} + {b[15], b};
        if (s[16] != s[15]) begin
            sat_add = s[16] ? 16'h8000 : 16'h7FFF;
        end else begin
            sat_add = s[15:0];
        end
    endfunction

    // ----------------------------------------
    // Link domain: synchronisers
    // ----------------------------------------
    logic slv_s1_ff, slv_s2_ff;
    logic req_s1_ff, req_s2_ff, req_s3_ff;
    logic sck_s1_ff, sck_s2_ff, sck_s3_ff;
    logic ncs_s1_ff, ncs_s2_ff;
    logic miso_s1_ff, miso_s2_ff;
    logic req_tgl_ff;

    always_ff @(posedge LINK_CLK or posedge RST) begin
        if (RST) begin
            slv_s1_ff <= 1'b0;
            slv_s2_ff <= 1'b0;
            req_s1_ff <= 1'b0;
            req_s2_ff <= 1'b0;
            req_s3_ff <= 1'b0;
            sck_s1_ff <= 1'b1;
            sck_s2_ff <= 1'b1;
            sck_s3_ff <= 1'b1;
            ncs_s1_ff <= 1'b1;
            ncs_s2_ff <= 1'b1;
            miso_s1_ff <= 1'b0;
            miso_s2_ff <= 1'b0;
        end else begin
            slv_s1_ff <= SLAVE_MODE;
            slv_s2_ff <= slv_s1_ff;
            req_s1_ff <= req_tgl_ff;
            req_s2_ff <= req_s1_ff;
            req_s3_ff <= req_s2_ff;
            sck_s1_ff <= SCK_I;
            sck_s2_ff <= sck_s1_ff;
            sck_s3_ff <= sck_s2_ff;
            ncs_s1_ff <= NCS_I;
            ncs_s2_ff <= ncs_s1_ff;
            miso_s1_ff <= MISO_I;
            miso_s2_ff <= miso_s1_ff;
        end
    end

    // ----------------------------------------
    // Link domain: burst engine
    // ----------------------------------------
    mif_pkg::mif_link_st_t lst_ff;
    logic [SW-1:0] div_ff;
    logic [6:0] bit_cnt_ff;
    logic [7:0] mosi_sh_ff;
    logic sck_ff;
    logic ncs_ff;
    logic done_tgl_ff;
    logic half_end;
    logic slv_rise;
    logic mst_rise;
    mif_pkg::mif_burst_t burst_ff;

    assign half_end = (div_ff == HALF_LAST);
    assign slv_rise = sck_s2_ff & ~sck_s3_ff;
    assign mst_rise = (lst_ff == mif_pkg::LK_SHIFT) && half_end && !sck_ff;

    always_ff @(posedge LINK_CLK or posedge RST) begin
        if (RST) begin
            lst_ff <= mif_pkg::LK_IDLE;
            div_ff <= '0;
            bit_cnt_ff <= '0;
            mosi_sh_ff <= '0;
            sck_ff <= 1'b1;
            ncs_ff <= 1'b1;
            done_tgl_ff <= 1'b0;
        end else begin
            unique case (lst_ff)
                mif_pkg::LK_IDLE: begin
                    div_ff <= '0;
                    bit_cnt_ff <= '0;
                    if (slv_s2_ff && !ncs_s2_ff) begin
                        lst_ff <= mif_pkg::LK_SLAVE;
                    end else if (!slv_s2_ff && (req_s2_ff != req_s3_ff)) begin
                        ncs_ff <= 1'b0;
                        mosi_sh_ff <= {1'b0, BURST_ADDR[6:0]};
                        lst_ff <= mif_pkg::LK_SHIFT;
                    end
                end
                mif_pkg::LK_SHIFT: begin
                    div_ff <= half_end ? '0 : div_ff + SW'(1);
                    if (half_end) begin
                        sck_ff <= ~sck_ff;
                        if (sck_ff && bit_cnt_ff != '0) begin
                            mosi_sh_ff <= {mosi_sh_ff[6:0], 1'b0};
                        end else if (!sck_ff) begin
                            bit_cnt_ff <= bit_cnt_ff + 7'd1;
                            if (bit_cnt_ff == MST_LAST) begin
                                lst_ff <= mif_pkg::LK_END;
                            end
                        end
                    end
                end
                mif_pkg::LK_SLAVE: begin
                    if (slv_rise) begin
                        bit_cnt_ff <= bit_cnt_ff + 7'd1;
                        if (bit_cnt_ff == SLV_LAST) begin
                            done_tgl_ff <= ~done_tgl_ff;
                            lst_ff <= mif_pkg::LK_END;
                        end
                    end
                end
                mif_pkg::LK_END: begin
                    div_ff <= half_end ? '0 : div_ff + SW'(1);
                    if (slv_s2_ff) begin
                        if (ncs_s2_ff) begin
                            lst_ff <= mif_pkg::LK_IDLE;
                        end
                    end else if (half_end) begin
                        ncs_ff <= 1'b1;
                        done_tgl_ff <= ~done_tgl_ff;
                        lst_ff <= mif_pkg::LK_IDLE;
                    end
                end
                default: begin
                    lst_ff <= mif_pkg::LK_IDLE;
                    sck_ff <= 1'b1;
                    ncs_ff <= 1'b1;
                end
            endcase
        end
    end

    // Data bytes shift in behind the address byte in master mode, from the first bit in slave mode; first byte ends up highest
    always_ff @(posedge LINK_CLK or posedge RST) begin
        if (RST) begin
            burst_ff <= '0;
        end else if (mst_rise && bit_cnt_ff >= 7'(`MIF_ADDR_BITS)) begin
            burst_ff <= {burst_ff[`MIF_BURST_BITS-2:0], miso_s2_ff};
        end else if (lst_ff == mif_pkg::LK_SLAVE && slv_rise) begin
            burst_ff <= {burst_ff[`MIF_BURST_BITS-2:0], miso_s2_ff};
        end
    end

    assign SCK_O = sck_ff;
    assign SCK_OE = ~slv_s2_ff;
    assign NCS_O = ncs_ff;
    assign NCS_OE = ~slv_s2_ff;
    assign MOSI_O = mosi_sh_ff[7];

    // ----------------------------------------
    // System domain: poll request and burst capture
    // ----------------------------------------
    logic [PW-1:0] poll_ff;
    logic busy_ff;
    logic done_s1_ff, done_s2_ff, done_s3_ff;
    logic done_edge;
    logic got_ff;
    mif_pkg::mif_burst_t cap_ff;

    assign done_edge = done_s2_ff ^ done_s3_ff;

    always_ff @(posedge CLK or posedge RST) begin
        if (RST) begin
            done_s1_ff <= 1'b0;
            done_s2_ff <= 1'b0;
            done_s3_ff <= 1'b0;
        end else begin
            done_s1_ff <= done_tgl_ff;
            done_s2_ff <= done_s1_ff;
            done_s3_ff <= done_s2_ff;
        end
    end

    always_ff @(posedge CLK or posedge RST) begin
        if (RST) begin
            poll_ff <= '0;
            busy_ff <= 1'b0;
            req_tgl_ff <= 1'b0;
        end else begin
            poll_ff <= (poll_ff == POLL_LAST) ? '0 : poll_ff + PW'(1);
            if (done_edge) begin
                busy_ff <= 1'b0;
            end else if (poll_ff == POLL_LAST && !busy_ff && !SLAVE_MODE) begin
                req_tgl_ff <= ~req_tgl_ff;
                busy_ff <= 1'b1;
            end
        end
    end

    // Burst stays still in the link domain until the next request, or the next frame in slave mode
    always_ff @(posedge CLK or posedge RST) begin
        if (RST) begin
            cap_ff <= '0;
            got_ff <= 1'b0;
        end else begin
            got_ff <= done_edge;
            if (done_edge) begin
                cap_ff <= burst_ff;
            end
        end
    end

    // ----------------------------------------
    // Scroll encoder
    // ----------------------------------------
    logic [1:0] z_s1_ff, z_s2_ff, z_prev_ff;
    logic [1:0] pos_now, pos_prev, pos_diff;
    logic [15:0] z_step;

    always_ff @(posedge CLK or posedge RST) begin
        if (RST) begin
            z_s1_ff <= '0;
            z_s2_ff <= '0;
            z_prev_ff <= '0;
        end else begin
            z_s1_ff <= {ZA, ZB};
            z_s2_ff <= z_s1_ff;
            z_prev_ff <= z_s2_ff;
        end
    end

    // Gray position along 00, 01, 11, 10
    assign pos_now = {z_s2_ff[1], z_s2_ff[1] ^ z_s2_ff[0]};
    assign pos_prev = {z_prev_ff[1], z_prev_ff[1] ^ z_prev_ff[0]};
    assign pos_diff = pos_now - pos_prev;

    always_comb begin
        unique case (pos_diff)
            2'h1: z_step = 16'h0001;
            2'h3: z_step = 16'hFFFF;
            default: z_step = 16'h0000;
        endcase
    end

    // ----------------------------------------
    // Buttons
    // ----------------------------------------
    logic [2:0] btn_s1_ff, btn_s2_ff;
    logic [2:0] btn_ff;
    logic [DW-1:0] deb_ff [3];

    always_ff @(posedge CLK or posedge RST) begin
        if (RST) begin
            btn_s1_ff <= 3'h7;
            btn_s2_ff <= 3'h7;
        end else begin
            btn_s1_ff <= BTN_N;
            btn_s2_ff <= btn_s1_ff;
        end
    end

    for (genvar i = 0; i < 3; i++) begin : g_btn
        always_ff @(posedge CLK or posedge RST) begin
            if (RST) begin
                deb_ff[i] <= '0;
                btn_ff[i] <= 1'b0;
            end else if (btn_ff[i] == ~btn_s2_ff[i]) begin
                deb_ff[i] <= '0;
            end else if (deb_ff[i] == DEB_LAST) begin
                deb_ff[i] <= '0;
                btn_ff[i] <= ~btn_s2_ff[i];
            end else begin
                deb_ff[i] <= deb_ff[i] + DW'(1);
            end
        end
    end

    assign BUTTONS_PRESSED = btn_ff;

    // ----------------------------------------
    // Accumulators and report hand-over
    // ----------------------------------------
    logic [15:0] acc_dx_ff, acc_dy_ff, acc_dz_ff;
    logic [15:0] in_dx, in_dy;
    logic [2:0] last_btn_ff;
    logic [7:0] surface_quality_ff;
    logic moved;
    logic buf_ready;
    logic push;
    mif_pkg::mif_report_t rep;

    assign moved = got_ff && cap_ff.motion[`MIF_MOTION_BIT];
    assign in_dx = moved ? {{4{cap_ff.xy_move_high[7]}}, cap_ff.xy_move_high[7:4], cap_ff.x_lo}
                         : 16'h0000;
    assign in_dy = moved ? {{4{cap_ff.xy_move_high[3]}}, cap_ff.xy_move_high[3:0], cap_ff.y_lo}
                         : 16'h0000;
    assign push = buf_ready && (acc_dx_ff != '0 || acc_dy_ff != '0 || acc_dz_ff != '0
                                || btn_ff != last_btn_ff);

    // New motion in the hand-over cycle starts the next report
    always_ff @(posedge CLK or posedge RST) begin
        if (RST) begin
            acc_dx_ff <= '0;
            acc_dy_ff <= '0;
            acc_dz_ff <= '0;
            last_btn_ff <= '0;
            surface_quality_ff <= '0;
        end else begin
            acc_dx_ff <= sat_add(push ? 16'h0000 : acc_dx_ff, in_dx);
            acc_dy_ff <= sat_add(push ? 16'h0000 : acc_dy_ff, in_dy);
            acc_dz_ff <= sat_add(push ? 16'h0000 : acc_dz_ff, z_step);
            if (push) begin
                last_btn_ff <= btn_ff;
            end
            if (got_ff) begin
                surface_quality_ff <= cap_ff.surface_quality;
            end
        end
    end

    assign rep = '{buttons: btn_ff, dx: acc_dx_ff, dy: acc_dy_ff, dz: acc_dz_ff,
                   surface_quality: surface_quality_ff};

    mif_buf #(
        .W($bits(mif_pkg::mif_report_t)),
        .DEPTH(`MIF_BUF_DEPTH)
    ) u_buf (
        .clk(CLK),
        .rst(RST),
        .in_valid(push),
        .in_ready(buf_ready),
        .in_data(rep),
        .out_valid(REPORT_VALID),
        .out_ready(REPORT_READY),
        .out_data(REPORT)
    );

endmodule // mif_front_end

`default_nettype wire

// >>> mif_front_end_assertions.sv
// Checker on the front end's top ports: serial framing, buttons, report flow.
// Bound from the bench; LINK_CLK and CLK are unrelated.
`timescale 1ns/1ps
`default_nettype none

module mif_front_end_assertions #(
    parameter int DEBOUNCE_CYC = 4
) (
    // Clocks and reset
    input wire logic CLK,
    input wire logic RST,
    input wire logic LINK_CLK,
    // Serial port
    input wire logic SLAVE_MODE,
    input wire logic SCK_O,
    input wire logic SCK_OE,
    input wire logic NCS_O,
    input wire logic NCS_OE,
    input wire logic MOSI_O,
    // Wheel, buttons, reports
    input wire logic ZA,
    input wire logic ZB,
    input wire logic [2:0] BTN_N,
    input wire mif_pkg::mif_report_t REPORT,
    input wire logic REPORT_VALID,
    input wire logic REPORT_READY,
    input wire logic [2:0] BUTTONS_PRESSED
);
    int rise_cnt_ff;
    int stable_cnt_ff;
    logic sck_prev_ff;
    logic [2:0] btn_prev_ff;

    // ----------------------------------------
    // Helper counters
    // ----------------------------------------
    always_ff @(posedge LINK_CLK or posedge RST) begin
        if (RST) begin
            rise_cnt_ff <= 0;
            sck_prev_ff <= 1'b1;
        end else begin
            sck_prev_ff <= SCK_O;
            if (NCS_O) rise_cnt_ff <= 0;
            else if (SCK_O && !sck_prev_ff) rise_cnt_ff <= rise_cnt_ff + 1;
        end
    end

    always_ff @(posedge CLK or posedge RST) begin
        if (RST) begin
            stable_cnt_ff <= 0;
            btn_prev_ff <= 3'h7;
        end else begin
            btn_prev_ff <= BTN_N;
            if (BTN_N != btn_prev_ff) stable_cnt_ff <= 0;
            else if (stable_cnt_ff < 1000) stable_cnt_ff <= stable_cnt_ff + 1;
        end
    end

    // ----------------------------------------
    // Properties
    // ----------------------------------------
    sequence s_step_seen;
        !$stable({ZA, ZB}) && !REPORT_VALID;
    endsequence

    sequence s_report_up;
        ##[2:8] REPORT_VALID;
    endsequence

    chk_report_hold: assert property (@(posedge CLK) disable iff (RST)
        REPORT_VALID && !REPORT_READY |=> REPORT_VALID && $stable(REPORT))
        else $error("report dropped or changed while stalled");
    chk_scroll_push: assert property (@(posedge CLK) disable iff (RST)
        s_step_seen |-> s_report_up) else $error("wheel step gave no report");
    chk_btn_cause: assert property (@(posedge CLK) disable iff (RST)
        $changed(BUTTONS_PRESSED[0]) |-> BUTTONS_PRESSED[0] != $past(BTN_N[0], 3)
        && BUTTONS_PRESSED[0] != $past(BTN_N[0], 4)) else $error("button taken too early");
    chk_btn_settle: assert property (@(posedge CLK) disable iff (RST)
        stable_cnt_ff == DEBOUNCE_CYC + 6 |-> BUTTONS_PRESSED == ~BTN_N)
        else $error("stable buttons not shown");
    chk_frame_len: assert property (@(posedge LINK_CLK) disable iff (RST)
        $rose(NCS_O) && SCK_OE |-> rise_cnt_ff == 72) else $error("frame clock count wrong");
    chk_read_addr: assert property (@(posedge LINK_CLK) disable iff (RST)
        $fell(NCS_O) |-> !MOSI_O && SCK_O) else $error("burst access is not a read");
    chk_mosi_fall: assert property (@(posedge LINK_CLK) disable iff (RST)
        !NCS_O && !$past(NCS_O) && $changed(MOSI_O) |-> $fell(SCK_O))
        else $error("data out moved off the falling clock");
    chk_idle_high: assert property (@(posedge LINK_CLK) disable iff (RST)
        NCS_O && SCK_OE |-> SCK_O) else $error("serial clock low outside frame");
    chk_slave_release: assert property (@(posedge LINK_CLK) disable iff (RST)
        SLAVE_MODE [*5] |-> !SCK_OE && !NCS_OE) else $error("pins driven in slave mode");
endmodule // mif_front_end_assertions

`default_nettype wire

// >>> mif_sensor.sv
// Behavioural optical sensor on the four-wire serial port, mode 3 framing.
// Data moves on the falling clock and is sampled on the rise.
`timescale 1ns/1ps
`default_nettype none

module mif_sensor #(
    parameter realtime LAG = 0.0
) (
    // Serial port wires
    input wire logic sck,
    input wire logic ncs_n,
    input wire logic mosi,
    output logic miso,
    // Control and observation
    input wire logic no_addr,
    input wire logic [63:0] burst,
    output logic [7:0] addr
);
    int bit_cnt = 0;
    logic [63:0] shift = 64'h0;

    initial begin
        miso = 1'b0;
        addr = 8'h00;
    end

    always @(negedge ncs_n) begin
        bit_cnt = 0;
        shift = burst;
    end

    always @(posedge sck) begin
        if (!ncs_n) begin
            if (bit_cnt < 8 && !no_addr) addr = {addr[6:0], mosi};
            bit_cnt = bit_cnt + 1;
        end
    end

    // Bytes back to back, no address per byte
    always @(negedge sck) begin
        if (!ncs_n && (no_addr || bit_cnt >= 8)) begin
            miso <= #(LAG) shift[63];
            shift = {shift[62:0], 1'b0};
        end
    end

    // Released line shows the inverse of its last level
    always @(posedge ncs_n) miso <= #(LAG) ~miso;
endmodule // mif_sensor

`default_nettype wire

// >>> mif_front_end_bench.sv
// Self-checking bench for the mouse input front end.
// Needs package, defines, design, buffer, sensor model and checker.
`timescale 1ns/1ps
`default_nettype none
`include "mif_defs.svh"
`define CHK(nm, e, g) begin n_checks++; if ((g) !== (e)) begin mismatches++; \
    $display("MISMATCH %s exp %0h got %0h", nm, e, g); end end

module mif_front_end_bench;
    localparam logic [7:0] BA = 8'hD3;
    logic clk = 1'b0, rst = 1'b1, link_clk = 1'b0, slave = 1'b0, sck_tb = 1'b1;
    logic ncs_tb = 1'b1, za = 1'b0, zb = 1'b0, ready = 1'b1;
    logic sck_o, sck_oe, ncs_o, ncs_oe, mosi, miso, valid;
    logic [2:0] btn_n = 3'h7, pressed, last_btn;
    logic [7:0] addr, last_sq;
    logic [63:0] burst = 64'h0;
    logic [15:0] sum_dx, sum_dy, sum_dz, exp_dz;
    mif_pkg::mif_report_t rep;
    int n_rep, dir, mismatches = 0, n_checks = 0, seed = 99, zi = 0;
    wire sck_w = sck_oe ? sck_o : sck_tb;
    wire ncs_w = ncs_oe ? ncs_o : ncs_tb;

    always #25 clk = ~clk;
    initial begin
        #1.7;
        forever #3 link_clk = ~link_clk;
    end

    mif_front_end #(.DEBOUNCE_CYC(4), .POLL_CYC(50), .SCK_HALF_CYC(3), .BURST_ADDR(BA)) dut (
        .CLK(clk), .RST(rst), .LINK_CLK(link_clk), .SLAVE_MODE(slave), .SCK_I(sck_w),
        .SCK_O(sck_o), .SCK_OE(sck_oe), .NCS_I(ncs_w), .NCS_O(ncs_o), .NCS_OE(ncs_oe),
        .MOSI_O(mosi), .MISO_I(miso), .ZA(za), .ZB(zb), .BTN_N(btn_n), .REPORT(rep),
        .REPORT_VALID(valid), .REPORT_READY(ready), .BUTTONS_PRESSED(pressed));
    mif_sensor #(.LAG(2.0)) sensor (.sck(sck_w), .ncs_n(ncs_w), .mosi(mosi), .miso(miso),
        .no_addr(slave), .burst(burst), .addr(addr));

    always @(posedge clk) begin
        if (valid === 1'b1 && ready) begin
            sum_dx += rep.dx;
            sum_dy += rep.dy;
            sum_dz += rep.dz;
            last_sq = rep.surface_quality;
            last_btn = rep.buttons;
            n_rep++;
        end
    end

    function automatic logic [15:0] sext(input logic [11:0] v);
        return {{4{v[11]}}, v};
    endfunction

    task automatic tick(input int n);
        repeat (n) @(negedge clk);
    endtask

    task automatic drain;
        tick(1);
        ready = 1'b1;
        tick(30);
    endtask

    task automatic clear_sums;
        drain;
        {sum_dx, sum_dy, sum_dz} = '0;
        n_rep = 0;
    endtask

    task automatic step(input int d, input logic rnd);
        logic [1:0] g [4] = '{2'h0, 2'h1, 2'h3, 2'h2};
        zi = (zi + d) & 3;
        {za, zb} = g[zi];
        if (rnd) ready = ($random(seed) & 3) != 0;
        tick(6);
    endtask

    task automatic slave_frame(input logic [63:0] d);
        burst = d;
        ncs_tb = 1'b0;
        repeat (64) begin
            #60 sck_tb = 1'b0;
            #60 sck_tb = 1'b1;
        end
        #60 ncs_tb = 1'b1;
        burst = {1'b0, d[62:0]};
    endtask

    task automatic motion(input logic slv);
        logic [11:0] x, y;
        logic [7:0] sq;
        logic [63:0] d;
        x = 12'($random(seed));
        y = 12'($random(seed));
        sq = 8'($random(seed));
        d = {8'h80, x[7:0], y[7:0], x[11:8], y[11:8], sq, 24'h123456};
        clear_sums;
        if (slv) slave_frame(d);
        else begin
            @(posedge ncs_w);
            burst = d;
            @(posedge ncs_w);
            burst = {1'b0, d[62:0]};
        end
        drain;
        `CHK("dx", sext(x), sum_dx)
        `CHK("dy", sext(y), sum_dy)
        `CHK("surface_quality", sq, last_sq)
        `CHK("reports", 1, n_rep)
    endtask

    task automatic close_out;
        $display("checks %0d mismatches %0d", n_checks, mismatches);
        if (mismatches == 0 && n_checks > 0) $display("All checks passed");
        else $display("Checks failed");
        $finish;
    endtask

    initial begin
        #1_000_000;
        mismatches++;
        close_out;
    end

    initial begin
        tick(3);
        rst = 1'b0;
        motion(1'b0);
        `CHK("addr", {1'b0, BA[6:0]}, addr)
        repeat (3) motion(1'b0);
        @(posedge ncs_w);
        tick(1);
        slave = 1'b1;
        tick(20);
        motion(1'b1);
        slave = 1'b0;
        clear_sums;
        exp_dz = 16'h0000;
        for (int k = 0; k < 24; k++) begin
            dir = ($random(seed) & 1) ? 1 : -1;
            exp_dz = exp_dz + 16'(dir);
            step(dir, 1'b1);
        end
        drain;
        `CHK("dz_sum", exp_dz, sum_dz)
        clear_sums;
        ready = 1'b0;
        repeat (3) step(1, 1'b0);
        tick(10);
        `CHK("held", 1'b1, valid)
        `CHK("first", 16'h0001, rep.dz)
        drain;
        `CHK("n_rep", 3, n_rep)
        `CHK("no_loss", 16'h0003, sum_dz)
        for (int k = 0; k < 6; k++) begin
            btn_n = 3'($random(seed));
            tick(14);
            `CHK("pressed", ~btn_n, pressed)
            btn_n = ~btn_n;
            tick(3);
            btn_n = ~btn_n;
            tick(14);
            `CHK("glitch", ~btn_n, pressed)
        end
        tick(20);
        `CHK("rep_btn", ~btn_n, last_btn)
        close_out;
    end
endmodule // mif_front_end_bench

bind mif_front_end mif_front_end_assertions #(.DEBOUNCE_CYC(DEBOUNCE_CYC)) chk (.CLK, .RST,
    .LINK_CLK, .SLAVE_MODE, .SCK_O, .SCK_OE, .NCS_O, .NCS_OE, .MOSI_O, .ZA, .ZB, .BTN_N,
    .REPORT, .REPORT_VALID, .REPORT_READY, .BUTTONS_PRESSED);

`default_nettype wire
